// file: pcg_cnt_if.sv
`timescale 1ns/1ps
// Bundle between the register block and one event counter.
interface pcg_cnt_if;
  logic wr;
  logic [31:0] wdata;
  logic clr;
  logic inc;
  logic [31:0] value;
  logic wrap;

  modport ctl (output wr, output wdata, output clr, output inc, input value, input wrap);
  modport cnt (input wr, input wdata, input clr, input inc, output value, output wrap);
endinterface

// file: pcg_counter.sv
`timescale 1ns/1ps
// One 32-bit event counter with whole-word load.
module pcg_counter (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  pcg_cnt_if.cnt port
);

  logic [31:0] count_q;
  logic wrap_q;

  // ------------------------------------------------------------------
  // Count, load and clear
  // ------------------------------------------------------------------
  // A software load wins over a same-cycle event so the written value sticks.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= 32'h0000_0000;
    end else if (port.wr) begin
      count_q <= port.wdata;
    end else if (port.clr) begin
      count_q <= 32'h0000_0000;
    end else if (port.inc) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // Wrap pulse, raised at the same edge as the all-ones to zero step.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= port.inc && !port.wr && !port.clr && (count_q == 32'hFFFF_FFFF);
    end
  end

  assign port.value = count_q;
  assign port.wrap = wrap_q;

endmodule

// file: pcg_pkg.sv
package pcg_pkg;

  // ------------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] PCG_OFF_COUNT0 = 8'h00;
  localparam logic [7:0] PCG_OFF_COUNT1 = 8'h04;
  localparam logic [7:0] PCG_OFF_COUNT2 = 8'h08;
  localparam logic [7:0] PCG_OFF_GROUP_CFG = 8'h10;
  localparam logic [7:0] PCG_OFF_STREAM_MATCH = 8'h14;
  localparam logic [7:0] PCG_OFF_CNT_EN_SET = 8'h20;
  localparam logic [7:0] PCG_OFF_CNT_EN_CLR = 8'h24;
  localparam logic [7:0] PCG_OFF_IRQ_EN_SET = 8'h28;
  localparam logic [7:0] PCG_OFF_IRQ_EN_CLR = 8'h2C;
  localparam logic [7:0] PCG_OFF_OVF_STATUS = 8'h30;
  localparam logic [7:0] PCG_OFF_MON_CTRL = 8'h34;

  // ------------------------------------------------------------------
  // Group configuration and stream match fields
  // ------------------------------------------------------------------
  localparam int PCG_CFG_NCNT_LSB = 24;
  localparam int PCG_CFG_STREAM_GROUP_ID_LSB = 16;
  localparam int PCG_CFG_CEN_BIT = 11;
  localparam int PCG_CFG_REVEAL_BIT = 10;
  localparam int PCG_CFG_FILT_LSB = 8;
  localparam logic [3:0] PCG_NUM_COUNTERS = 4'h3;
  localparam logic [6:0] PCG_STREAM_GROUP = 7'h00;
  localparam int PCG_MATCH_MASK_LSB = 16;

  // Monitor control fields.
  localparam int PCG_CTRL_EN_BIT = 0;
  localparam int PCG_CTRL_RESET_BIT = 1;
  localparam int PCG_CTRL_NA_BIT = 2;

  // Reset values of the block's own control state.
  localparam logic [1:0] PCG_FILT_RESET = 2'h0;
  localparam logic [7:0] PCG_INDEX_RESET = 8'h00;

  typedef enum logic [1:0] {
    PCG_FILT_GLOBAL = 2'h0,
    PCG_FILT_STREAM = 2'h1,
    PCG_FILT_BANK = 2'h2,
    PCG_FILT_RSVD = 2'h3
  } pcg_filter_type;

endpackage

// file: pcg_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Counter register reads and writes the whole 32-bit count at once.
// - With no access restriction, writes to a disabled counter still load.
// - Counter disabled when its enable bit clears or group enable is zero.
// - Group config bits 27:24 read three, writes ignored.
// - Group config bits 22:16 read zero, writes ignored.
// - Group config bit 11 is the group count enable, mirrors global enable.
// - Group config bit 10 reveals the group to the indexed bank.
// - Filter bits 9:8: global, stream match, bank match, reserved.
// - Index bits 7:0 used as bank number only under bank filtering.
// - Stream mask bit one ignores that ID bit in the comparison.
// - ID and mask hold only the configured width; upper bits read zero.
// - Counter enable vector is three bits in 2:0, upper bits reserved.
// - Enable set and clear registers both read the enable vector.
// - Writing ones sets or clears enables; zeros leave them alone.
// - Interrupt enable vector is three bits, one per counter.
// - No overflow interrupt while the global monitor enable is zero.
// - Interrupt enable set and clear registers both read the vector.
// - Writing ones sets or clears interrupt enables; zeros ignored.
// - Counters are 32 bits wide.
module pcg_top
  import pcg_pkg::*;
#(
  parameter int STREAM_ID_BITS = 15,
  parameter int BANK_BITS = 8
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [2:0] event_i,
  input wire logic [STREAM_ID_BITS-1:0] event_stream_i,
  input wire logic [BANK_BITS-1:0] event_bank_i,
  output logic [2:0] overflow_irq_o,
  output logic bank_reveal_o,
  output logic [BANK_BITS-1:0] bank_index_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // The stream ID and its mask share the low and high halves of one word.
  if (STREAM_ID_BITS < 1 || STREAM_ID_BITS > 15) begin : g_bad_sid
    $error("Stream_id_bits must be 1 to 15 bits.");
  end
  if (BANK_BITS != 8) begin : g_bad_bank
    $error("Bank index must be 8 bits.");
  end

  localparam int NCNT = 3;

  // The fixed count field and the counter vectors must agree in size.
  if (NCNT != int'(PCG_NUM_COUNTERS)) begin : g_bad_count
    $error("Counter count and count field disagree.");
  end

  // ------------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------------
  logic mon_enable_q;
  logic no_restrict_q;
  logic reveal_q;
  logic [1:0] filter_q;
  logic [7:0] index_q;
  logic [STREAM_ID_BITS-1:0] match_id_q;
  logic [STREAM_ID_BITS-1:0] match_mask_q;
  logic [NCNT-1:0] cnt_en_q;
  logic [NCNT-1:0] irq_en_q;
  logic [NCNT-1:0] ovf_q;
  logic [31:0] rdata_q;
  logic [NCNT-1:0] irq_q;

  logic wr_ctrl;
  logic wr_cfg;
  logic wr_match;
  logic wr_cnt_en_set;
  logic wr_cnt_en_clr;
  logic wr_irq_en_set;
  logic wr_irq_en_clr;
  logic wr_ovf_clr;
  logic counter_reset;
  logic [NCNT-1:0] cnt_wr;
  logic [NCNT-1:0] cnt_inc;
  logic [NCNT-1:0] cnt_wrap;
  logic [31:0] cnt_val [NCNT];
  logic event_pass;
  logic [31:0] rd_mux;

  // Write decodes. Each register except the counters, which decode in the counter loop,
  // gets one decoded strobe here, so that no two processes can disagree about which address a write belongs to.
  assign wr_ctrl = reg_wr_i && (reg_addr_i == PCG_OFF_MON_CTRL);
  assign wr_cfg = reg_wr_i && (reg_addr_i == PCG_OFF_GROUP_CFG);
  assign wr_match = reg_wr_i && (reg_addr_i == PCG_OFF_STREAM_MATCH);
  assign wr_cnt_en_set = reg_wr_i && (reg_addr_i == PCG_OFF_CNT_EN_SET);
  assign wr_cnt_en_clr = reg_wr_i && (reg_addr_i == PCG_OFF_CNT_EN_CLR);
  assign wr_irq_en_set = reg_wr_i && (reg_addr_i == PCG_OFF_IRQ_EN_SET);
  assign wr_irq_en_clr = reg_wr_i && (reg_addr_i == PCG_OFF_IRQ_EN_CLR);
  assign wr_ovf_clr = reg_wr_i && (reg_addr_i == PCG_OFF_OVF_STATUS);

  // The reset-counters bit is write-only; it zeroes the counts but leaves the
  // overflow flags alone, so software does not lose a pending wrap.
  assign counter_reset = wr_ctrl && reg_wdata_i[PCG_CTRL_RESET_BIT];

  // ------------------------------------------------------------------
  // Monitor control
  // ------------------------------------------------------------------
  // The group enable bit and the global enable are one flop, so both
  // writes land on the same state and always read back alike. A control
  // write and a group write never meet, as one strobe decodes one address.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mon_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      mon_enable_q <= reg_wdata_i[PCG_CTRL_EN_BIT];
    end else if (wr_cfg) begin
      mon_enable_q <= reg_wdata_i[PCG_CFG_CEN_BIT];
    end
  end

  // Access restriction flag; when set, disabled counters refuse loads.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      no_restrict_q <= 1'b0;
    end else if (wr_ctrl) begin
      no_restrict_q <= reg_wdata_i[PCG_CTRL_NA_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Group configuration and stream match
  // ------------------------------------------------------------------
  // Count and group fields are constants, so writes to them fall away.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reveal_q <= 1'b0;
      filter_q <= PCG_FILT_RESET;
      index_q <= PCG_INDEX_RESET;
    end else if (wr_cfg) begin
      reveal_q <= reg_wdata_i[PCG_CFG_REVEAL_BIT];
      filter_q <= reg_wdata_i[PCG_CFG_FILT_LSB +: 2];
      index_q <= reg_wdata_i[7:0];
    end
  end

  // Only the configured ID width is stored; upper bits never exist.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      match_id_q <= '0;
      match_mask_q <= '0;
    end else if (wr_match) begin
      match_id_q <= reg_wdata_i[STREAM_ID_BITS-1:0];
      match_mask_q <= reg_wdata_i[PCG_MATCH_MASK_LSB +: STREAM_ID_BITS];
    end
  end

  // ------------------------------------------------------------------
  // Enable vectors
  // ------------------------------------------------------------------
  // Reset value is left to software in principle; zero is safe here.
  // Software may not rely on it, but a known zero keeps every counter idle
  // until it is enabled on purpose. Written zeros leave bits untouched.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_en_q <= '0;
    end else if (wr_cnt_en_set) begin
      cnt_en_q <= cnt_en_q | reg_wdata_i[NCNT-1:0];
    end else if (wr_cnt_en_clr) begin
      cnt_en_q <= cnt_en_q & ~reg_wdata_i[NCNT-1:0];
    end
  end

  // Interrupt enables; software sets these before starting counters.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en_q <= '0;
    end else if (wr_irq_en_set) begin
      irq_en_q <= irq_en_q | reg_wdata_i[NCNT-1:0];
    end else if (wr_irq_en_clr) begin
      irq_en_q <= irq_en_q & ~reg_wdata_i[NCNT-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Event filter
  // ------------------------------------------------------------------
  // Bank index counts only under bank filtering; reserved code counts none.
  // The event's stream and bank travel with it in the same cycle, so no
  // register is put in front of the comparison.
  always_comb begin
    case (pcg_filter_type'(filter_q))
      PCG_FILT_GLOBAL: event_pass = 1'b1;
      PCG_FILT_STREAM: event_pass =
        &((~(event_stream_i ^ match_id_q)) | match_mask_q);
      PCG_FILT_BANK: event_pass = (event_bank_i == index_q);
      default: event_pass = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------------
  // A counter loads from software unless restricted while disabled, and
  // counts only when both its own and the group enable are set.
  // Each counter keeps its own wrap pulse; the flags below collect them.
  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    pcg_cnt_if cif ();
    logic active;
    assign active = cnt_en_q[i] && mon_enable_q;
    assign cnt_wr[i] = reg_wr_i && (reg_addr_i == 8'(4 * i))
                       && (!no_restrict_q || active);
    assign cnt_inc[i] = active && event_i[i] && event_pass;
    assign cif.wr = cnt_wr[i];
    assign cif.wdata = reg_wdata_i;
    assign cif.clr = counter_reset;
    assign cif.inc = cnt_inc[i];
    assign cnt_val[i] = cif.value;
    assign cnt_wrap[i] = cif.wrap;
    pcg_counter u_counter (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .port(cif.cnt)
    );
  end

  // ------------------------------------------------------------------
  // Overflow status and interrupt
  // ------------------------------------------------------------------
  // A wrap in the cycle of a clear write still sets its flag.
  // Losing a wrap there would hide a whole turn of the counter from software.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_q <= '0;
    end else begin
      if (wr_ovf_clr) begin
        ovf_q <= (ovf_q & ~reg_wdata_i[NCNT-1:0]) | cnt_wrap;
      end else begin
        ovf_q <= ovf_q | cnt_wrap;
      end
    end
  end

  // Registered so the pin never glitches while enables change.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q <= '0;
    end else begin
      irq_q <= ovf_q & irq_en_q & {NCNT{mon_enable_q}};
    end
  end

  // ------------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------------
  // Read multiplexer. Unmapped addresses and unused bits read as zero, so
  // software can probe the map safely; a read changes no state at all.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_i == PCG_OFF_COUNT0) begin
      rd_mux = cnt_val[0];
    end else if (reg_addr_i == PCG_OFF_COUNT1) begin
      rd_mux = cnt_val[1];
    end else if (reg_addr_i == PCG_OFF_COUNT2) begin
      rd_mux = cnt_val[2];
    end else if (reg_addr_i == PCG_OFF_GROUP_CFG) begin
      rd_mux[PCG_CFG_NCNT_LSB +: 4] = PCG_NUM_COUNTERS;
      rd_mux[PCG_CFG_STREAM_GROUP_ID_LSB +: 7] = PCG_STREAM_GROUP;
      rd_mux[PCG_CFG_CEN_BIT] = mon_enable_q;
      rd_mux[PCG_CFG_REVEAL_BIT] = reveal_q;
      rd_mux[PCG_CFG_FILT_LSB +: 2] = filter_q;
      rd_mux[7:0] = index_q;
    end else if (reg_addr_i == PCG_OFF_STREAM_MATCH) begin
      rd_mux[STREAM_ID_BITS-1:0] = match_id_q;
      rd_mux[PCG_MATCH_MASK_LSB +: STREAM_ID_BITS] = match_mask_q;
    end else if (reg_addr_i == PCG_OFF_CNT_EN_SET || reg_addr_i == PCG_OFF_CNT_EN_CLR) begin
      rd_mux[NCNT-1:0] = cnt_en_q;
    end else if (reg_addr_i == PCG_OFF_IRQ_EN_SET || reg_addr_i == PCG_OFF_IRQ_EN_CLR) begin
      rd_mux[NCNT-1:0] = irq_en_q;
    end else if (reg_addr_i == PCG_OFF_OVF_STATUS) begin
      rd_mux[NCNT-1:0] = ovf_q;
    end else if (reg_addr_i == PCG_OFF_MON_CTRL) begin
      rd_mux[PCG_CTRL_EN_BIT] = mon_enable_q;
      rd_mux[PCG_CTRL_NA_BIT] = no_restrict_q;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // The reveal bit only means something under bank filtering;
  // other settings are left to software to avoid.
  logic reveal_out_q;
  logic [7:0] index_out_q;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reveal_out_q <= 1'b0;
      index_out_q <= 8'h00;
    end else begin
      reveal_out_q <= reveal_q;
      index_out_q <= index_q;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign overflow_irq_o = irq_q;
  assign bank_reveal_o = reveal_out_q;
  assign bank_index_o = index_out_q;

endmodule

// file: pcg_top_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checker for the counter group
// ------------------------------------------------------------------
module pcg_top_props
  import pcg_pkg::*;
#(
  parameter int STREAM_ID_BITS = 15,
  parameter int BANK_BITS = 8
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [2:0] event_i,
  input wire logic [STREAM_ID_BITS-1:0] event_stream_i,
  input wire logic [BANK_BITS-1:0] event_bank_i,
  input wire logic [2:0] overflow_irq_o,
  input wire logic bank_reveal_o,
  input wire logic [BANK_BITS-1:0] bank_index_o
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // The outputs lag the register by one edge, so the new value shows two edges on.
  property p_reveal;
    logic [31:0] d;
    (reg_wr_i && reg_addr_i == PCG_OFF_GROUP_CFG, d = reg_wdata_i)
      |-> ##2 bank_reveal_o == d[PCG_CFG_REVEAL_BIT] && bank_index_o == d[7:0];
  endproperty

  // A cleared enable must silence its interrupt once the registered output catches up.
  property p_irq_clr;
    logic [2:0] d;
    (reg_wr_i && reg_addr_i == PCG_OFF_IRQ_EN_CLR, d = reg_wdata_i[2:0])
      |-> ##2 (overflow_irq_o & d) == 3'h0;
  endproperty

  chk_rdata_idle: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
    else $error("read data outside its slot");
  chk_cfg_fixed: assert property (reg_rd_i &&
    reg_addr_i == PCG_OFF_GROUP_CFG |=>
    reg_rdata_o[PCG_CFG_NCNT_LSB +: 4] == PCG_NUM_COUNTERS &&
    reg_rdata_o[PCG_CFG_STREAM_GROUP_ID_LSB +: 7] == PCG_STREAM_GROUP)
    else $error("fixed config fields wrong");
  chk_reveal_follow: assert property (p_reveal)
    else $error("reveal or index output wrong");
  chk_irq_gate_off: assert property (reg_wr_i && reg_addr_i == PCG_OFF_MON_CTRL &&
    !reg_wdata_i[PCG_CTRL_EN_BIT] |-> ##2 overflow_irq_o == 3'h0)
    else $error("interrupt while monitor disabled");
  chk_irq_en_clear: assert property (p_irq_clr)
    else $error("interrupt after enable cleared");
  chk_match_upper: assert property (reg_rd_i &&
    reg_addr_i == PCG_OFF_STREAM_MATCH |=> !reg_rdata_o[31] && !reg_rdata_o[15])
    else $error("unimplemented match bits set");
  chk_cnten_mirror: assert property (reg_rd_i &&
    reg_addr_i == PCG_OFF_CNT_EN_SET ##1 reg_rd_i && reg_addr_i == PCG_OFF_CNT_EN_CLR
    |=> reg_rdata_o == $past(reg_rdata_o))
    else $error("enable set and clear views differ");
  chk_irqen_mirror: assert property (reg_rd_i &&
    reg_addr_i == PCG_OFF_IRQ_EN_SET ##1 reg_rd_i && reg_addr_i == PCG_OFF_IRQ_EN_CLR
    |=> reg_rdata_o == $past(reg_rdata_o))
    else $error("interrupt enable views differ");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h3C |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");

  cov_irq: cover property (overflow_irq_o[0]);
  cov_reveal: cover property (bank_reveal_o);
  cov_count: cover property (event_i != 3'h0);
endmodule

bind pcg_top pcg_top_props #(.STREAM_ID_BITS(STREAM_ID_BITS), .BANK_BITS(BANK_BITS)) chk_u (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .event_i(event_i), .event_stream_i(event_stream_i),
  .event_bank_i(event_bank_i), .overflow_irq_o(overflow_irq_o),
  .bank_reveal_o(bank_reveal_o), .bank_index_o(bank_index_o));

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} pcg_reg_row_type;
  typedef struct {logic [31:0] c; logic [14:0] s; logic [7:0] b; logic [31:0] e;} pcg_flt_row_type;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [2:0] event_i = 3'h0;
  logic [14:0] event_stream_i = 15'h0;
  logic [7:0] event_bank_i = 8'h00;
  logic [2:0] overflow_irq_o;
  logic bank_reveal_o;
  logic [7:0] bank_index_o;
  int fails = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic [31:0] q2;
  pcg_reg_row_type rows[10];
  pcg_flt_row_type frows[7];

  pcg_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .event_i(event_i), .event_stream_i(event_stream_i),
    .event_bank_i(event_bank_i), .overflow_irq_o(overflow_irq_o),
    .bank_reveal_o(bank_reveal_o), .bank_index_o(bank_index_o));

  // 20 MHz system clock.
  always #25 clk_sys_i = ~clk_sys_i;

  // ------------------------------------------------------------------
  // Bus, event and comparison helpers
  // ------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Two reads with no gap, as the mirror checks need them adjacent.
  task automatic rd2(input logic [7:0] a1, input logic [7:0] a2, output logic [31:0] d1,
                     output logic [31:0] d2);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a1;
    @(posedge clk_sys_i);
    reg_addr_i <= a2;
    #1 d1 = reg_rdata_o;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d2 = reg_rdata_o;
  endtask

  task automatic ev(input logic [2:0] e, input logic [14:0] s, input logic [7:0] b);
    @(posedge clk_sys_i);
    event_i <= e;
    event_stream_i <= s;
    event_bank_i <= b;
    @(posedge clk_sys_i);
    event_i <= 3'h0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 160 cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rows = '{
      '{PCG_OFF_GROUP_CFG, 32'h0000_0D5A, 32'h0F7F_0FFF, 32'h0300_0D5A},
      '{PCG_OFF_GROUP_CFG, 32'hFFFF_F0A5, 32'h0F7F_0FFF, 32'h0300_00A5},
      '{PCG_OFF_STREAM_MATCH, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h7FFF_7FFF},
      '{PCG_OFF_IRQ_EN_SET, 32'h0000_0006, 32'h0000_0007, 32'h0000_0006},
      '{PCG_OFF_IRQ_EN_CLR, 32'hFFFF_FFF9, 32'h0000_0007, 32'h0000_0006},
      '{PCG_OFF_CNT_EN_SET, 32'hFFFF_FFFF, 32'h0000_0007, 32'h0000_0007},
      '{PCG_OFF_CNT_EN_CLR, 32'h0000_0005, 32'h0000_0007, 32'h0000_0002},
      '{PCG_OFF_COUNT0, 32'hA5A5_5A5A, 32'hFFFF_FFFF, 32'hA5A5_5A5A},
      '{PCG_OFF_COUNT1, 32'h0123_4567, 32'hFFFF_FFFF, 32'h0123_4567},
      '{8'h3C, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000}};
    // Bank rows set the reveal bit only with bank filtering selected.
    frows = '{
      '{32'h0000_0800, 15'h0000, 8'h00, 32'h1}, '{32'h0000_0900, 15'h001F, 8'h00, 32'h2},
      '{32'h0000_0900, 15'h0032, 8'h00, 32'h2},
      '{32'h0000_0E07, 15'h0000, 8'h07, 32'h3},
      '{32'h0000_0E07, 15'h0000, 8'h08, 32'h3},
      '{32'h0000_0B07, 15'h0000, 8'h07, 32'h3},
      '{32'h0000_0207, 15'h0000, 8'h07, 32'h3}};
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk($sformatf("reg %h", rows[i].a),
          q & rows[i].m, rows[i].e);
    end
    rd2(PCG_OFF_CNT_EN_SET, PCG_OFF_CNT_EN_CLR, q, q2);
    chk("enable set view", q & 32'h7, 32'h2);
    chk("enable clear view", q2 & 32'h7, 32'h2);
    rd2(PCG_OFF_IRQ_EN_SET, PCG_OFF_IRQ_EN_CLR, q, q2);
    chk("irq enable set view", q & 32'h7, 32'h6);
    chk("irq enable clear view", q2 & 32'h7, 32'h6);
    // Filtering: counter 0 alone enabled, match ignores the low four ID bits.
    wr(PCG_OFF_CNT_EN_CLR, 32'h7);
    wr(PCG_OFF_CNT_EN_SET, 32'h1);
    wr(PCG_OFF_STREAM_MATCH, 32'h000F_0012);
    wr(PCG_OFF_COUNT0, 32'h0);
    foreach (frows[i]) begin
      wr(PCG_OFF_GROUP_CFG, frows[i].c);
      ev(3'h7, frows[i].s, frows[i].b);
      rd(PCG_OFF_COUNT0, q);
      chk($sformatf("filter row %0d", i), q, frows[i].e);
      chk("reveal outputs", {23'h0, bank_reveal_o, bank_index_o},
          {23'h0, frows[i].c[10], frows[i].c[7:0]});
    end
    rd(PCG_OFF_COUNT1, q);
    chk("disabled counter", q, 32'h0123_4567);
    wr(PCG_OFF_CNT_EN_CLR, 32'h1);
    wr(PCG_OFF_GROUP_CFG, 32'h0000_0800);
    ev(3'h1, 15'h0, 8'h00);
    rd(PCG_OFF_COUNT0, q);
    chk("cleared enable", q, 32'h3);
    // Wrap of counter 0 raises its interrupt three edges after the event.
    wr(PCG_OFF_IRQ_EN_SET, 32'h1);
    wr(PCG_OFF_COUNT0, 32'hFFFF_FFFF);
    wr(PCG_OFF_CNT_EN_SET, 32'h1);
    ev(3'h1, 15'h0, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("overflow irq", {29'h0, overflow_irq_o}, 32'h1);
    rd(PCG_OFF_COUNT0, q);
    chk("wrapped count", q, 32'h0);
    rd(PCG_OFF_OVF_STATUS, q);
    chk("overflow flag", q, 32'h1);
    wr(PCG_OFF_MON_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq global off", {29'h0, overflow_irq_o}, 32'h0);
    rd(PCG_OFF_GROUP_CFG, q);
    chk("cfg enable mirror off", q & 32'h800, 32'h0);
    wr(PCG_OFF_MON_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq global on", {29'h0, overflow_irq_o}, 32'h1);
    wr(PCG_OFF_IRQ_EN_CLR, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq enable cleared", {29'h0, overflow_irq_o}, 32'h0);
    // Flag clear by status write, then the control bit that zeroes all counts.
    wr(PCG_OFF_OVF_STATUS, 32'h1);
    rd(PCG_OFF_OVF_STATUS, q);
    chk("overflow flag cleared", q, 32'h0);
    wr(PCG_OFF_MON_CTRL, 32'h3);
    rd(PCG_OFF_COUNT1, q);
    chk("counter reset bit", q, 32'h0);
    // Second reset in mid-run brings the control state back to zero.
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(PCG_OFF_GROUP_CFG, q);
    chk("cfg after reset", q & 32'h0F7F_0FFF, 32'h0300_0000);
    rd(PCG_OFF_CNT_EN_SET, q);
    chk("enables after reset", q, 32'h0);
    // With access restricted, a disabled counter refuses a software load.
    wr(PCG_OFF_MON_CTRL, 32'h4);
    wr(PCG_OFF_COUNT2, 32'h0000_1234);
    rd(PCG_OFF_COUNT2, q);
    chk("restricted load", q, 32'h0);
    tally_and_finish();
  end
endmodule
